// ==== cma_mem_addressing.sv ====
// memory-addressing core: stack, pointers, banked data decode, flag register
// Operation
// - flags, accumulator, bank, both pointers and pclatch copied to shadows on interrupt entry, restored on return
// - sixteen-entry, fifteen-bit hardware return stack separate from data memory
// - stack overrun/underrun sets its flag and, if enabled, requests software reset
// - two sixteen-bit pointers reach all file registers and program memory
// - pointer access to program memory costs one extra instruction cycle
// - program counter is fifteen bits, 32K words of fourteen bits
// - program addresses beyond implemented size wrap within it
// - reset starts at address zero, interrupts vector to address four
// - implemented program memory is 8K or 16K words by variant
// - pointer high bit seven set reads low byte of program word
// - pointer writes aimed at program memory do nothing
// - data memory is thirty-two banks of 128 bytes
// - bank holds 12 core, 20 peripheral, 80 general, 16 common bytes
// - direct accesses use the bank last written to the bank chooser
// - unimplemented data locations read as zero
// - twelve-bit data address: five bank bits, seven offset bits
// - core registers appear at offsets zero to eleven of every bank
// - flag-affecting ops writing flag register keep their own Z, DC, C
// - timeout and power-down flags ignore software writes
// - clear of flag register zeroes top three bits, sets Z, keeps others
// - carry and digit-carry are active-low borrows in subtraction
// - digit-carry from bit three, carry from most significant bit
// - timeout cleared on watchdog expiry, set at power-up, clear or sleep
// - common RAM bytes map to the same storage from every bank
`timescale 1ns/1ps
`include "cpu_mem_regs.svh"

module cma_mem_addressing #(
	parameter int PROG_WORDS = 16384,
	parameter int STACK_DEPTH = `CMA_STACK_DEPTH
) (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire cma_pkg::cma_acc_t   accKind,
	input  wire logic [6:0]          fileOffset,
	input  wire logic                fileWrite,
	input  wire logic [7:0]          fileWdata,
	input  wire logic                clearOp,
	input  wire logic                flagsUpdate,
	input  wire logic [2:0]          aluFlags,
	output logic [7:0]               fileRdata,
	output logic                     fileStall,
	output logic [14:0]              progAddr,
	input  wire logic [13:0]         progRdata,
	input  wire logic                pcLoad,
	input  wire logic [14:0]         pcNext,
	input  wire logic                callPush,
	input  wire logic                retPop,
	input  wire logic                irqTake,
	input  wire logic                irqReturn,
	input  wire logic                wdtClear,
	input  wire logic                sleepEnter,
	input  wire logic                wdtExpire,
	input  wire logic                stackResetEnable,
	output logic [14:0]              pc,
	output logic                     stackOverrunFlag,
	output logic                     stackUnderrunFlag,
	output logic                     softReset,
	output logic [7:0]               accumulator,
	output logic [4:0]               bankChooser
);
	import cma_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH + 1);
	// the variant size must be a power of two for the mask to wrap
	localparam logic [14:0] PROG_MASK = 15'(PROG_WORDS - 1);
	// banked general RAM, stored linearly as bank * 80 + offset - 0x20
	localparam int GPR_TOTAL = `CMA_BANKS * `CMA_GPR_BYTES;

	typedef struct packed {
		cma_state_t                    st;
		logic [14:0]                   pc;
		logic [STACK_DEPTH-1:0][14:0]  stk;
		logic [SP_W-1:0]               sp;
		logic                          ovf;
		logic                          unf;
		logic                          srst;
		logic [15:0]                   ptr0;
		logic [15:0]                   ptr1;
		logic [4:0]                    bank;
		logic [7:0]                    acc;
		logic [7:0]                    pclatch;
		logic [7:0]                    irq;
		logic [7:0]                    flags;
		logic [7:0]                    shFlags;
		logic [7:0]                    shAcc;
		logic [4:0]                    shBank;
		logic [15:0]                   shPtr0;
		logic [15:0]                   shPtr1;
		logic [7:0]                    shPclatch;
		logic [GPR_TOTAL-1:0][7:0]     general_ram;
		logic [`CMA_COMMON_BYTES-1:0][7:0]          com;
		logic [7:0]                    rdata;
	} cma_state_s_t;

	cma_state_s_t r;
	cma_state_s_t next_r;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic cma_region_t regionOf(input logic [6:0] off);
		if (off <= `CMA_CORE_LAST)
			return CMA_REG_CORE;
		else if (off <= `CMA_SFR_LAST)
			return CMA_REG_NONE;
		else if (off <= `CMA_GPR_LAST)
			return CMA_REG_GPR;
		else
			return CMA_REG_COMMON;
	endfunction : regionOf

	function automatic logic [11:0] gprIndex(input logic [4:0] bnk, input logic [6:0] off);
		logic [11:0] base;
		base = 12'(bnk) * 12'(`CMA_GPR_BYTES);
		return 12'(base + 12'(off - `CMA_GPR_FIRST));
	endfunction : gprIndex

	// core register read mux, same in every bank
	function automatic logic [7:0] coreRead(input cma_state_s_t s, input logic [6:0] off);
		logic [7:0] v;
		v = 8'h00;
		case (off)
			`CMA_OFF_PCL:     v = s.pc[7:0];
			`CMA_OFF_FLAGS:   v = {3'b000, s.flags[4:0]};
			`CMA_OFF_PTR0L:   v = s.ptr0[7:0];
			`CMA_OFF_PTR0H:   v = s.ptr0[15:8];
			`CMA_OFF_PTR1L:   v = s.ptr1[7:0];
			`CMA_OFF_PTR1H:   v = s.ptr1[15:8];
			`CMA_OFF_BANK:    v = {3'b000, s.bank};
			`CMA_OFF_ACC:     v = s.acc;
			`CMA_OFF_PCLATCH: v = s.pclatch;
			`CMA_OFF_IRQ:     v = s.irq;
			default:          v = 8'h00;
		endcase
		return v;
	endfunction : coreRead

	logic [11:0] dataAddr;
	logic [15:0] ptrSel;
	logic        isInd;
	logic        toProg;
	logic        stackFull;
	logic        stackEmpty;
	logic        doPush;
	logic        doPop;
	logic [7:0]  rd;

	always_comb begin
		isInd = (accKind == CMA_ACC_IND0) || (accKind == CMA_ACC_IND1);
		ptrSel = (accKind == CMA_ACC_IND1) ? r.ptr1 : r.ptr0;
		toProg = isInd && ptrSel[8 + `CMA_PROG_MSB_BIT];
		dataAddr = isInd ? ptrSel[11:0] : {r.bank, fileOffset};
		// an interrupt entry takes a stack slot just like a call
		doPush = callPush || irqTake;
		doPop = !doPush && (retPop || irqReturn);
		stackFull = (r.sp == SP_W'(STACK_DEPTH));
		stackEmpty = (r.sp == '0);
	end

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.srst = 1'b0;
		rd = 8'h00;
		progAddr = r.pc & PROG_MASK;

		// ----------------------------------------------------------------
		// program counter and return stack
		// ----------------------------------------------------------------
		if (irqTake) begin
			next_r.pc = `CMA_IRQ_VEC;
		end else if (pcLoad) begin
			next_r.pc = pcNext & PROG_MASK;
		end
		if (doPush) begin
			if (stackFull) begin
				// the push is dropped so the stored return addresses stay intact
				next_r.ovf = 1'b1;
				next_r.srst = stackResetEnable;
			end else begin
				next_r.stk[r.sp[SP_W-2:0]] = r.pc;
				next_r.sp = SP_W'(r.sp + 1'b1);
			end
		end else if (doPop) begin
			if (stackEmpty) begin
				next_r.unf = 1'b1;
				next_r.srst = stackResetEnable;
			end else begin
				next_r.sp = SP_W'(r.sp - 1'b1);
				next_r.pc = r.stk[SP_W'(r.sp - 1'b1)] & PROG_MASK;
			end
		end

		// ----------------------------------------------------------------
		// context save and restore
		// ----------------------------------------------------------------
		if (irqTake) begin
			next_r.shFlags = r.flags;
			next_r.shAcc = r.acc;
			next_r.shBank = r.bank;
			next_r.shPtr0 = r.ptr0;
			next_r.shPtr1 = r.ptr1;
			next_r.shPclatch = r.pclatch;
		end else if (irqReturn) begin
			next_r.flags = r.shFlags;
			next_r.acc = r.shAcc;
			next_r.bank = r.shBank;
			next_r.ptr0 = r.shPtr0;
			next_r.ptr1 = r.shPtr1;
			next_r.pclatch = r.shPclatch;
		end

		// ----------------------------------------------------------------
		// data access
		// ----------------------------------------------------------------
		if (toProg) begin
			progAddr = ptrSel[14:0] & PROG_MASK;
			rd = progRdata[7:0];
			// the byte is registered in both cycles; the first raises the stall, the second ends the access
			case (r.st)
				CMA_ST_IDLE:  next_r.st = CMA_ST_FETCH;
				CMA_ST_FETCH: next_r.st = CMA_ST_IDLE;
				default:      next_r.st = CMA_ST_IDLE;
			endcase
			// writes to program memory are dropped
		end else if (accKind != CMA_ACC_NONE) begin
			next_r.st = CMA_ST_IDLE;
			case (regionOf(dataAddr[6:0]))
				CMA_REG_CORE: begin
					rd = coreRead(r, dataAddr[6:0]);
					if (fileWrite) begin
						case (dataAddr[6:0])
							`CMA_OFF_PCL:     next_r.pc = {r.pclatch[6:0], fileWdata} & PROG_MASK;
							`CMA_OFF_FLAGS: begin
								// a clear aimed at the flag register forces Z to one; a plain write loads Z, DC, C from the write data
								if (clearOp) begin
									next_r.flags = {3'b000, r.flags[4:3], 1'b1, r.flags[1:0]};
								end else if (flagsUpdate) begin
									next_r.flags[7:5] = 3'b000;
								end else begin
									next_r.flags[2:0] = fileWdata[2:0];
								end
							end
							`CMA_OFF_PTR0L:   next_r.ptr0[7:0] = fileWdata;
							`CMA_OFF_PTR0H:   next_r.ptr0[15:8] = fileWdata;
							`CMA_OFF_PTR1L:   next_r.ptr1[7:0] = fileWdata;
							`CMA_OFF_PTR1H:   next_r.ptr1[15:8] = fileWdata;
							`CMA_OFF_BANK:    next_r.bank = fileWdata[4:0];
							`CMA_OFF_ACC:     next_r.acc = fileWdata;
							`CMA_OFF_PCLATCH: next_r.pclatch = fileWdata;
							`CMA_OFF_IRQ:     next_r.irq = fileWdata;
							default: ;
						endcase
					end
				end
				CMA_REG_GPR: begin
					rd = r.general_ram[gprIndex(dataAddr[11:7], dataAddr[6:0])];
					if (fileWrite)
						next_r.general_ram[gprIndex(dataAddr[11:7], dataAddr[6:0])] = fileWdata;
				end
				CMA_REG_COMMON: begin
					rd = r.com[dataAddr[3:0]];
					if (fileWrite)
						next_r.com[dataAddr[3:0]] = fileWdata;
				end
				default: rd = 8'h00;
			endcase
		end else begin
			next_r.st = CMA_ST_IDLE;
		end

		// ----------------------------------------------------------------
		// flag register
		// ----------------------------------------------------------------
		// arithmetic flags from the execution unit, borrow sense already inverted there
		if (flagsUpdate)
			next_r.flags[2:0] = aluFlags;

		// reset-status flags; hardware events win over software writes
		if (wdtClear || sleepEnter)
			next_r.flags[`CMA_FLG_TO] = 1'b1;
		if (wdtClear)
			next_r.flags[`CMA_FLG_PD] = 1'b1;
		if (sleepEnter)
			next_r.flags[`CMA_FLG_PD] = 1'b0;
		if (wdtExpire)
			next_r.flags[`CMA_FLG_TO] = 1'b0;
		// read data is registered: it stands for exactly the cycle after the access
		next_r.rdata = rd;
	end

	// combinational so the requester sees the extra cycle in the cycle it asks
	assign fileStall = toProg && (r.st == CMA_ST_IDLE);

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r.st <= CMA_ST_IDLE;
			r.pc <= `CMA_RESET_VEC;
			r.stk <= '0;
			r.sp <= '0;
			r.ovf <= 1'b0;
			r.unf <= 1'b0;
			r.srst <= 1'b0;
			r.ptr0 <= 16'h0000;
			r.ptr1 <= 16'h0000;
			r.bank <= 5'h00;
			r.acc <= 8'h00;
			r.pclatch <= 8'h00;
			r.irq <= 8'h00;
			r.flags <= `CMA_FLG_RESET;
			r.shFlags <= 8'h00;
			r.shAcc <= 8'h00;
			r.shBank <= 5'h00;
			r.shPtr0 <= 16'h0000;
			r.shPtr1 <= 16'h0000;
			r.shPclatch <= 8'h00;
			r.general_ram <= '0;
			r.com <= '0;
			r.rdata <= 8'h00;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign fileRdata = r.rdata;
	assign pc = r.pc;
	assign stackOverrunFlag = r.ovf;
	assign stackUnderrunFlag = r.unf;
	assign softReset = r.srst;
	assign accumulator = r.acc;
	assign bankChooser = r.bank;

endmodule : cma_mem_addressing

// ==== cma_mem_monitor.sv ====
// port assertions for the memory-addressing block
`timescale 1ns/1ps
module cma_mem_monitor #(
	parameter int PROG_WORDS = 16384
) (
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire cma_pkg::cma_acc_t accKind,
	input wire logic [6:0]        fileOffset,
	input wire logic              fileWrite,
	input wire logic [7:0]        fileWdata,
	input wire logic [7:0]        fileRdata,
	input wire logic              fileStall,
	input wire logic              pcLoad,
	input wire logic [14:0]       pcNext,
	input wire logic              callPush,
	input wire logic              retPop,
	input wire logic              irqTake,
	input wire logic              irqReturn,
	input wire logic [14:0]       pc,
	input wire logic              stackOverrunFlag,
	input wire logic              stackUnderrunFlag,
	input wire logic              softReset,
	input wire logic [7:0]        accumulator,
	input wire logic [4:0]        bankChooser
);
	import cma_pkg::*;
	logic dirWr, dirRd, evt;
	assign dirWr = accKind == CMA_ACC_DIR && fileWrite;
	assign dirRd = accKind == CMA_ACC_DIR && !fileWrite;
	assign evt = callPush || retPop || irqTake || irqReturn;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// ----
	// checks
	// ----
	a_pc_reset: assert property ($fell(reset) |-> pc == 15'h0000)
		else $error("pc not zero after reset");
	a_pc_wrap: assert property (pcLoad && !evt |=> pc == ($past(pcNext) & 15'(PROG_WORDS - 1)))
		else $error("pc load not wrapped");
	a_irq_vector: assert property (irqTake |=> pc == 15'h0004)
		else $error("irq not at vector");
	a_acc_write: assert property (dirWr && fileOffset == 7'h09 && !evt |=> accumulator == $past(fileWdata))
		else $error("accumulator not written");
	a_bank_write: assert property (dirWr && fileOffset == 7'h08 && !evt |=> bankChooser == $past(fileWdata[4:0]))
		else $error("bank not written");
	a_sfr_zero: assert property (dirRd && fileOffset inside {[7'h0c:7'h1f]} |=> fileRdata == 8'h00)
		else $error("unimplemented read not zero");
	a_stall_source: assert property (fileStall |-> accKind == CMA_ACC_IND0 || accKind == CMA_ACC_IND1)
		else $error("stall without pointer");
	a_stall_once: assert property (fileStall |=> !fileStall)
		else $error("stall longer than one cycle");
	a_flag_sticky: assert property (!($fell(stackOverrunFlag) || $fell(stackUnderrunFlag)))
		else $error("stack flag dropped");
	a_soft_pulse: assert property (softReset |=> !softReset)
		else $error("soft reset not a pulse");
	a_soft_cause: assert property (softReset |-> stackOverrunFlag || stackUnderrunFlag)
		else $error("soft reset without stack fault");
	c_stall: cover property (fileStall);
	c_overrun: cover property ($rose(stackOverrunFlag));
	c_soft: cover property (softReset);
endmodule : cma_mem_monitor

bind cma_mem_addressing cma_mem_monitor #(.PROG_WORDS(PROG_WORDS)) cma_mem_monitor_i (
	.clk_sys, .reset, .accKind, .fileOffset, .fileWrite, .fileWdata, .fileRdata, .fileStall, .pcLoad, .pcNext,
	.callPush, .retPop, .irqTake, .irqReturn, .pc, .stackOverrunFlag, .stackUnderrunFlag, .softReset,
	.accumulator, .bankChooser
);

// ==== cma_pkg.sv ====
// types shared by the memory-addressing block
package cma_pkg;

	typedef enum logic [2:0] {
		CMA_ACC_NONE  = 3'b000,
		CMA_ACC_DIR   = 3'b001,
		CMA_ACC_IND0  = 3'b010,
		CMA_ACC_IND1  = 3'b011
	} cma_acc_t;

	typedef enum logic [1:0] {
		CMA_ST_IDLE  = 2'b00,
		CMA_ST_FETCH = 2'b01
	} cma_state_t;

	typedef enum logic [1:0] {
		CMA_REG_NONE   = 2'b00,
		CMA_REG_CORE   = 2'b01,
		CMA_REG_GPR    = 2'b10,
		CMA_REG_COMMON = 2'b11
	} cma_region_t;

endpackage : cma_pkg

// ==== cma_prog_rom.sv ====
// program memory model feeding fetch words back to the block
`timescale 1ns/1ps
module cma_prog_rom (
	input  wire logic [14:0] progAddr,
	output logic      [13:0] progRdata
);
	// fourteen-bit words whose contents follow from the address
	assign progRdata = {progAddr[5:0], progAddr[7:0] ^ 8'ha5};
endmodule : cma_prog_rom

// ==== cpu_mem_regs.svh ====
// constants for the memory-addressing block: offsets, fields, reset values
`ifndef CPU_MEM_REGS_SVH
`define CPU_MEM_REGS_SVH

// ----------------------------------------------------------------
// core register offsets inside every bank
// ----------------------------------------------------------------
`define CMA_OFF_IND0      7'h00
`define CMA_OFF_IND1      7'h01
`define CMA_OFF_PCL       7'h02
`define CMA_OFF_FLAGS     7'h03
`define CMA_OFF_PTR0L     7'h04
`define CMA_OFF_PTR0H     7'h05
`define CMA_OFF_PTR1L     7'h06
`define CMA_OFF_PTR1H     7'h07
`define CMA_OFF_BANK      7'h08
`define CMA_OFF_ACC       7'h09
`define CMA_OFF_PCLATCH   7'h0a
`define CMA_OFF_IRQ       7'h0b
`define CMA_CORE_LAST     7'h0b
`define CMA_SFR_LAST      7'h1f
`define CMA_GPR_FIRST     7'h20
`define CMA_GPR_LAST      7'h6f
`define CMA_COMMON_FIRST  7'h70

// ----------------------------------------------------------------
// flag register fields
// ----------------------------------------------------------------
`define CMA_FLG_C         0
`define CMA_FLG_DC        1
`define CMA_FLG_Z         2
`define CMA_FLG_PD        3
`define CMA_FLG_TO        4
`define CMA_FLG_RESET     8'h18

// ----------------------------------------------------------------
// vectors and sizes
// ----------------------------------------------------------------
`define CMA_RESET_VEC     15'h0000
`define CMA_IRQ_VEC       15'h0004
`define CMA_PROG_MSB_BIT  7
`define CMA_STACK_DEPTH   16
`define CMA_PC_WIDTH      15
`define CMA_BANKS         32
`define CMA_GPR_BYTES     80
`define CMA_COMMON_BYTES  16

`endif

// ==== testbench.sv ====
// self-checking bench for the memory-addressing block
`timescale 1ns/1ps
`define CK(n, e, s) begin checksDone++; if ((s) !== (e)) begin errorCnt++; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
	import cma_pkg::*;
	localparam cma_acc_t D = CMA_ACC_DIR, P0 = CMA_ACC_IND0, P1 = CMA_ACC_IND1;
	logic        clk_sys = 1'b0, reset = 1'b1, fileWrite = 1'b0, clearOp = 1'b0, flagsUpdate = 1'b0;
	logic        pcLoad = 1'b0, stackResetEnable = 1'b0, stv = 1'b0, srSeen = 1'b0;
	logic        fileStall, stackOverrunFlag, stackUnderrunFlag, softReset;
	logic [2:0]  aluFlags = 3'h0;
	logic [4:0]  bankChooser;
	logic [6:0]  fileOffset = 7'h00, ev = 7'h00;
	logic [7:0]  fileWdata = 8'h00, fileRdata, accumulator, rdv;
	logic [13:0] progRdata;
	logic [14:0] pcNext = 15'h0000, pc, progAddr;
	cma_acc_t    accKind = CMA_ACC_NONE;
	int          errorCnt = 0, checksDone = 0;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (softReset === 1'b1) srSeen <= 1'b1;
	cma_mem_addressing #(.PROG_WORDS(8192)) cma_mem_addressing_i (
		.clk_sys, .reset, .accKind, .fileOffset, .fileWrite, .fileWdata, .clearOp, .flagsUpdate, .aluFlags,
		.fileRdata, .fileStall, .progAddr, .progRdata, .pcLoad, .pcNext, .callPush(ev[6]), .retPop(ev[5]),
		.irqTake(ev[4]), .irqReturn(ev[3]), .wdtClear(ev[2]), .sleepEnter(ev[1]), .wdtExpire(ev[0]),
		.stackResetEnable, .pc, .stackOverrunFlag, .stackUnderrunFlag, .softReset, .accumulator, .bankChooser
	);
	cma_prog_rom cma_prog_rom_i (.progAddr, .progRdata);
	// ----
	// access tasks
	// ----
	task xf(input cma_acc_t k, input logic [6:0] o, input logic w, input logic [7:0] d, input logic [4:0] f);
		@(posedge clk_sys);
		accKind <= k;
		fileOffset <= o;
		fileWrite <= w;
		fileWdata <= d;
		{clearOp, flagsUpdate, aluFlags} <= f;
		#1 stv = fileStall;
		@(posedge clk_sys);
		// program fetch holds the request one more cycle
		if (stv) @(posedge clk_sys);
		accKind <= CMA_ACC_NONE;
		fileWrite <= 1'b0;
		{clearOp, flagsUpdate, aluFlags} <= 5'h00;
		#1 rdv = fileRdata;
	endtask : xf
	task wr(input logic [6:0] o, input logic [7:0] d);
		xf(D, o, 1'b1, d, 5'h00);
	endtask : wr
	task rc(input cma_acc_t k, input logic [6:0] o, input logic [7:0] e, input string n);
		xf(k, o, 1'b0, 8'h00, 5'h00);
		`CK(n, e, rdv)
	endtask : rc
	task pul(input logic [6:0] e);
		@(posedge clk_sys);
		ev <= e;
		@(posedge clk_sys);
		ev <= 7'h00;
		#1;
	endtask : pul
	task ld(input logic [14:0] v);
		@(posedge clk_sys);
		pcLoad <= 1'b1;
		pcNext <= v;
		@(posedge clk_sys);
		pcLoad <= 1'b0;
		#1;
	endtask : ld
	task wrapUp;
		$display("checks %0d mismatches %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrapUp
	// ----
	// tests
	// ----
	initial begin
		repeat (5000) @(posedge clk_sys);
		errorCnt++;
		wrapUp;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		#1 `CK("pc", 15'h0000, pc)
		rc(D, 7'h03, 8'h18, "flags");
		$display("reset done");
		wr(7'h09, 8'h55);
		wr(7'h08, 8'hff);
		`CK("bank out", 5'h1f, bankChooser)
		rc(D, 7'h08, 8'h1f, "bank");
		wr(7'h08, 8'h02);
		wr(7'h20, 8'ha1);
		wr(7'h08, 8'h03);
		wr(7'h20, 8'hb2);
		wr(7'h70, 8'hc3);
		rc(D, 7'h20, 8'hb2, "gpr b3");
		wr(7'h08, 8'h02);
		rc(D, 7'h20, 8'ha1, "gpr b2");
		rc(D, 7'h70, 8'hc3, "common");
		rc(D, 7'h09, 8'h55, "acc");
		`CK("acc out", 8'h55, accumulator)
		wr(7'h10, 8'h77);
		rc(D, 7'h10, 8'h00, "sfr");
		$display("banks done");
		wr(7'h04, 8'h20);
		wr(7'h05, 8'h01);
		rc(P0, 7'h00, 8'ha1, "ptr0");
		wr(7'h06, 8'hef);
		wr(7'h07, 8'h0f);
		xf(P1, 7'h00, 1'b1, 8'h5a, 5'h00);
		wr(7'h08, 8'h1f);
		rc(D, 7'h6f, 8'h5a, "gpr b31");
		wr(7'h06, 8'h05);
		wr(7'h07, 8'ha0);
		rc(P1, 7'h00, 8'ha0, "prog");
		`CK("stall", 1'b1, stv)
		xf(P1, 7'h00, 1'b1, 8'h99, 5'h00);
		rc(D, 7'h05, 8'h01, "ptr0h");
		$display("pointers done");
		wr(7'h03, 8'hff);
		rc(D, 7'h03, 8'h1f, "flags wr");
		xf(D, 7'h03, 1'b1, 8'h00, 5'b01101);
		rc(D, 7'h03, 8'h1d, "flags alu");
		wr(7'h03, 8'h03);
		xf(D, 7'h03, 1'b1, 8'h00, 5'b10000);
		rc(D, 7'h03, 8'h1f, "flags clr");
		pul(7'h01);
		rc(D, 7'h03, 8'h0f, "wdt exp");
		pul(7'h02);
		rc(D, 7'h03, 8'h17, "sleep");
		pul(7'h04);
		rc(D, 7'h03, 8'h1f, "wdt clr");
		$display("flags done");
		ld(15'h7fff);
		`CK("prog addr", 15'h1fff, progAddr)
		`CK("pc wrap", 15'h1fff, pc)
		ld(15'h0123);
		wr(7'h09, 8'h11);
		pul(7'h10);
		`CK("irq vec", 15'h0004, pc)
		wr(7'h09, 8'h22);
		pul(7'h08);
		`CK("irq ret", 15'h0123, pc)
		rc(D, 7'h09, 8'h11, "shadow");
		pul(7'h20);
		`CK("unf", 1'b1, stackUnderrunFlag)
		`CK("pc hold", 15'h0123, pc)
		`CK("no sr", 1'b0, srSeen)
		@(posedge clk_sys);
		stackResetEnable <= 1'b1;
		repeat (16) pul(7'h40);
		`CK("ovf early", 1'b0, stackOverrunFlag)
		pul(7'h40);
		repeat (2) @(posedge clk_sys);
		`CK("ovf", 1'b1, stackOverrunFlag)
		`CK("soft rst", 1'b1, srSeen)
		$display("stack done");
		wrapUp;
	end
endmodule : testbench
